// file: pkg/emc_pkg.sv
// Constants shared by the energy-manager configuration register bank.
// Assumes a byte-wide register port driven by a serial front end on the same clock.
// What this block does
// - Storage limit bit selects 9.9 or 11.0 V.
// - Battery low-threshold codes 000-100 map 2.4-3.2 V.
// - Charge current codes 000-011 map 2-16 mA.
// - Code 100 is 50 mA; 101-111 are undefined.
// - Early-warning codes 0000-1001 map 2.4-4.8 V.
// - Warning bit 4 enables early-warning detection.
// - Input bit 4 sets pulse output high impedance in standby and active.
// - Profile index joins register 7 and 8 bits.
// - Profile zero means fixed mode, else optimized.
// - Margin codes map 3.41 to 5.91 V target.
// - Energy value spans registers 1 to 4, MSB first.
// - Energy value clears when a charge cycle begins.
// - Actual storage code updates in charge, active only.
// - Target code loads when charge state begins.
// - Storage codes follow the five-bit voltage ladder.
package emc_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] EMC_OFS_ENERGY_3     = 8'h01;
    localparam logic [7:0] EMC_OFS_ENERGY_2     = 8'h02;
    localparam logic [7:0] EMC_OFS_ENERGY_1     = 8'h03;
    localparam logic [7:0] EMC_OFS_ENERGY_0     = 8'h04;
    localparam logic [7:0] EMC_OFS_STORE_NOW    = 8'h05;
    localparam logic [7:0] EMC_OFS_TARGET       = 8'h06;
    localparam logic [7:0] EMC_OFS_PROFILE_HIGH = 8'h07;
    localparam logic [7:0] EMC_OFS_MODE_COMMAND = 8'h08;
    localparam logic [7:0] EMC_OFS_INPUT_CFG    = 8'h0a;
    localparam logic [7:0] EMC_OFS_WARNING_CFG  = 8'h0b;
    localparam logic [7:0] EMC_OFS_LIMIT_CFG    = 8'h0c;
    localparam logic [7:0] EMC_OFS_MARGIN_CFG   = 8'h0d;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int EMC_LIMIT_BIT    = 4;
    localparam int EMC_VMIN_LSB     = 0;
    localparam int EMC_HIZ_BIT      = 4;
    localparam int EMC_ICH_LSB      = 5;
    localparam int EMC_EW_LSB       = 0;
    localparam int EMC_EW_EN_BIT    = 4;
    localparam int EMC_PROF_HI_LSB  = 0;
    localparam int EMC_PROF_LO_LSB  = 4;
    localparam int EMC_MARGIN_LSB   = 0;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic       EMC_RST_LIMIT   = 1'b0;
    localparam logic [2:0] EMC_RST_VMIN    = 3'h0;
    localparam logic       EMC_RST_HIZ     = 1'b0;
    localparam logic [2:0] EMC_RST_ICH     = 3'h2;
    localparam logic [3:0] EMC_RST_EW      = 4'h0;
    localparam logic       EMC_RST_EW_EN   = 1'b0;
    localparam logic [5:0] EMC_RST_PROFILE = 6'h00;
    localparam logic [1:0] EMC_RST_MARGIN  = 2'h3;
    localparam logic [4:0] EMC_RST_LEVEL   = 5'h00;

    // ****************************************************************
    // Code limits
    // ****************************************************************
    localparam logic [2:0] EMC_ICH_EMERGENCY = 3'h4;
    localparam logic [2:0] EMC_VMIN_LAST     = 3'h4;
    localparam logic [3:0] EMC_EW_LAST       = 4'h9;

endpackage

// file: verilog/emc_sync.sv
// Two-stage synchroniser for a bus of slowly changing levels.
// Assumes the source holds each code stable for several clock cycles.
`timescale 1ns/1ps
module emc_sync #(
    parameter int WIDTH = 5
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                meta_q[b] <= 1'b0;
                sync_o[b] <= 1'b0;
            end else if (ce_i) begin
                meta_q[b] <= async_i[b];
                sync_o[b] <= meta_q[b];
            end
        end
    end
endmodule

// file: verilog/emc_energy_gauge.sv
// Energy accumulator behind the fuel gauge registers.
// Assumes add requests and charge-start pulses come from logic on the same clock.
`timescale 1ns/1ps
module emc_energy_gauge #(
    parameter int WIDTH     = 32,
    parameter int ADD_WIDTH = 16
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    input  wire logic                 clear_i,
    input  wire logic                 add_i,
    input  wire logic [ADD_WIDTH-1:0] amount_i,
    output logic      [WIDTH-1:0]     total_o
);
    logic [WIDTH:0] sum;

    assign sum = {1'b0, total_o} + {{(WIDTH + 1 - ADD_WIDTH){1'b0}}, amount_i};

    // Saturating so a long discharge never wraps to a small reading.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            total_o <= '0;
        end else if (ce_i) begin
            if (clear_i) begin
                total_o <= '0;
            end else if (add_i) begin
                total_o <= sum[WIDTH] ? '1 : sum[WIDTH-1:0];
            end
        end
    end
endmodule

// file: verilog/emc_config_regs.sv
// Configuration and read-back register bank of the energy manager.
// Assumes a serial front end on clk_i that issues one-cycle byte reads and writes,
// a state sequencer on clk_i, and an asynchronous storage-level code from the converter.
`timescale 1ns/1ps
module emc_config_regs
    import emc_pkg::*;
#(
    parameter int ADD_WIDTH = 16
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [7:0]           reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output logic      [7:0]           reg_rdata_o,
    output logic                      reg_rvalid_o,
    input  wire logic                 charge_start_i,
    input  wire logic                 in_charge_i,
    input  wire logic                 in_active_i,
    input  wire logic                 in_standby_i,
    input  wire logic                 energy_add_i,
    input  wire logic [ADD_WIDTH-1:0] energy_amount_i,
    input  wire logic [4:0]           store_level_async_i,
    input  wire logic [4:0]           target_level_i,
    output logic                      limit_high_o,
    output logic      [15:0]          limit_mv_o,
    output logic      [2:0]           vmin_code_o,
    output logic      [15:0]          vmin_mv_o,
    output logic      [2:0]           ich_code_o,
    output logic      [15:0]          ich_ma_x10_o,
    output logic                      ich_undefined_o,
    output logic      [3:0]           ew_code_o,
    output logic      [15:0]          ew_mv_o,
    output logic                      ew_enable_o,
    output logic                      pulse_out_hiz_o,
    output logic                      pulse_out_to_battery_o,
    output logic      [5:0]           profile_index_o,
    output logic                      fixed_mode_o,
    output logic      [1:0]           margin_code_o,
    output logic      [15:0]          margin_mv_o,
    output logic      [15:0]          store_now_mv_o,
    output logic      [15:0]          target_mv_o
);

    // ****************************************************************
    // Write-only configuration fields
    // ****************************************************************
    logic       limit_q;
    logic [2:0] vmin_q;
    logic       hiz_q;
    logic [2:0] ich_q;
    logic [3:0] ew_q;
    logic       ew_en_q;
    logic [1:0] prof_hi_q;
    logic [3:0] prof_lo_q;
    logic [1:0] margin_q;

    logic wr;
    assign wr = ce_i && reg_wr_i;

    // Fields keep their value until rewritten; only reset restores defaults.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            limit_q <= EMC_RST_LIMIT;
        end else if (wr && reg_addr_i == EMC_OFS_LIMIT_CFG) begin
            limit_q <= reg_wdata_i[EMC_LIMIT_BIT];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            vmin_q <= EMC_RST_VMIN;
            hiz_q  <= EMC_RST_HIZ;
            ich_q  <= EMC_RST_ICH;
        end else if (wr && reg_addr_i == EMC_OFS_INPUT_CFG) begin
            vmin_q <= reg_wdata_i[EMC_VMIN_LSB +: 3];
            hiz_q  <= reg_wdata_i[EMC_HIZ_BIT];
            ich_q  <= reg_wdata_i[EMC_ICH_LSB +: 3];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ew_q    <= EMC_RST_EW;
            ew_en_q <= EMC_RST_EW_EN;
        end else if (wr && reg_addr_i == EMC_OFS_WARNING_CFG) begin
            ew_q    <= reg_wdata_i[EMC_EW_LSB +: 4];
            ew_en_q <= reg_wdata_i[EMC_EW_EN_BIT];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prof_hi_q <= EMC_RST_PROFILE[5:4];
        end else if (wr && reg_addr_i == EMC_OFS_PROFILE_HIGH) begin
            prof_hi_q <= reg_wdata_i[EMC_PROF_HI_LSB +: 2];
        end
    end

    // The low nibble of the command register carries mode commands handled elsewhere.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prof_lo_q <= EMC_RST_PROFILE[3:0];
        end else if (wr && reg_addr_i == EMC_OFS_MODE_COMMAND) begin
            prof_lo_q <= reg_wdata_i[EMC_PROF_LO_LSB +: 4];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            margin_q <= EMC_RST_MARGIN;
        end else if (wr && reg_addr_i == EMC_OFS_MARGIN_CFG) begin
            margin_q <= reg_wdata_i[EMC_MARGIN_LSB +: 2];
        end
    end

    // ****************************************************************
    // Field decode
    // ****************************************************************
    assign limit_high_o    = limit_q;
    assign vmin_code_o     = vmin_q;
    assign ich_code_o      = ich_q;
    assign ew_code_o       = ew_q;
    assign ew_enable_o     = ew_en_q;
    assign margin_code_o   = margin_q;
    assign profile_index_o = {prof_hi_q, prof_lo_q};
    assign fixed_mode_o    = (profile_index_o == 6'h00);
    assign ich_undefined_o = (ich_q > EMC_ICH_EMERGENCY);

    // High impedance applies only in standby and active; with the bit clear there the pin follows the battery, elsewhere neither output is set.
    assign pulse_out_hiz_o        = hiz_q && (in_standby_i || in_active_i);
    assign pulse_out_to_battery_o = !hiz_q && (in_standby_i || in_active_i);

    always_comb begin
        limit_mv_o = limit_q ? 16'h2af8 : 16'h26ac;
    end

    always_comb begin
        unique case (vmin_q)
            3'h0:    vmin_mv_o = 16'h0960;
            3'h1:    vmin_mv_o = 16'h0a28;
            3'h2:    vmin_mv_o = 16'h0af0;
            3'h3:    vmin_mv_o = 16'h0bb8;
            3'h4:    vmin_mv_o = 16'h0c80;
            default: vmin_mv_o = 16'h0000;
        endcase
    end

    // Undefined current codes report zero so the converter can refuse them.
    always_comb begin
        unique case (ich_q)
            3'h0:    ich_ma_x10_o = 16'h0014;
            3'h1:    ich_ma_x10_o = 16'h0028;
            3'h2:    ich_ma_x10_o = 16'h0050;
            3'h3:    ich_ma_x10_o = 16'h00a0;
            3'h4:    ich_ma_x10_o = 16'h01f4;
            default: ich_ma_x10_o = 16'h0000;
        endcase
    end

    always_comb begin
        unique case (ew_q)
            4'h0:    ew_mv_o = 16'h0960;
            4'h1:    ew_mv_o = 16'h0a28;
            4'h2:    ew_mv_o = 16'h0af0;
            4'h3:    ew_mv_o = 16'h0bb8;
            4'h4:    ew_mv_o = 16'h0c80;
            4'h5:    ew_mv_o = 16'h0d48;
            4'h6:    ew_mv_o = 16'h0e10;
            4'h7:    ew_mv_o = 16'h0fa0;
            4'h8:    ew_mv_o = 16'h1130;
            4'h9:    ew_mv_o = 16'h12c0;
            default: ew_mv_o = 16'h0000;
        endcase
    end

    always_comb begin
        unique case (margin_q)
            2'h0: margin_mv_o = 16'h0d52;
            2'h1: margin_mv_o = 16'h1126;
            2'h2: margin_mv_o = 16'h145a;
            2'h3: margin_mv_o = 16'h1716;
        endcase
    end

    // ****************************************************************
    // Storage-level codes
    // ****************************************************************
    logic [4:0] level_sync;
    logic [4:0] store_now_q;
    logic [4:0] target_q;

    emc_sync #(
        .WIDTH (5)
    ) u_level_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .async_i (store_level_async_i),
        .sync_o  (level_sync)
    );

    // Standby leakage is deliberately not tracked, so the code may read high after a long idle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            store_now_q <= EMC_RST_LEVEL;
        end else if (ce_i && (in_charge_i || in_active_i)) begin
            store_now_q <= level_sync;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            target_q <= EMC_RST_LEVEL;
        end else if (ce_i && charge_start_i) begin
            target_q <= target_level_i;
        end
    end

    // Millivolts of each storage code, indexed by the code itself.
    localparam logic [15:0] LADDER_MV [32] = '{
        16'h0578,
        16'h05e6,
        16'h0708,
        16'h088e,
        16'h0960,
        16'h0a28,
        16'h0ae6,
        16'h0bc2,
        16'h0c80,
        16'h0d52,
        16'h0e1a,
        16'h0f96,
        16'h1126,
        16'h12c0,
        16'h145a,
        16'h15d6,
        16'h1716,
        16'h1784,
        16'h1900,
        16'h1996,
        16'h1a90,
        16'h1be4,
        16'h1c3e,
        16'h1e00,
        16'h1ffe,
        16'h21ca,
        16'h238c,
        16'h253a,
        16'h26b6,
        16'h285a,
        16'h29c2,
        16'h2b3e
    };

    assign store_now_mv_o = LADDER_MV[store_now_q];
    assign target_mv_o    = LADDER_MV[target_q];

    // ****************************************************************
    // Fuel gauge
    // ****************************************************************
    logic [31:0] energy_total;
    logic [31:0] energy_snap_q;

    emc_energy_gauge #(
        .WIDTH     (32),
        .ADD_WIDTH (ADD_WIDTH)
    ) u_gauge (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .clear_i  (charge_start_i),
        .add_i    (energy_add_i),
        .amount_i (energy_amount_i),
        .total_o  (energy_total)
    );

    // Reading the top byte freezes the lower three so a multi-byte read is never torn.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            energy_snap_q <= '0;
        end else if (ce_i && reg_rd_i && reg_addr_i == EMC_OFS_ENERGY_3) begin
            energy_snap_q <= energy_total;
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    logic [7:0] rdata_d;

    always_comb begin
        unique case (reg_addr_i)
            EMC_OFS_ENERGY_3:  rdata_d = energy_total[31:24];
            EMC_OFS_ENERGY_2:  rdata_d = energy_snap_q[23:16];
            EMC_OFS_ENERGY_1:  rdata_d = energy_snap_q[15:8];
            EMC_OFS_ENERGY_0:  rdata_d = energy_snap_q[7:0];
            EMC_OFS_STORE_NOW: rdata_d = {3'h0, store_now_q};
            EMC_OFS_TARGET:    rdata_d = {3'h0, target_q};
            default:           rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_d;
            end
        end
    end

endmodule

// file: sim/emc_config_regs_props.sv
// Concurrent checks on the ports of the energy-manager register bank.
// Assumes one clock domain on clk_i and an asynchronous active-high reset.
`timescale 1ns/1ps
module emc_config_regs_props
    import emc_pkg::*;
#(
    parameter int ADD_WIDTH = 16
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic        reg_rvalid_o,
    input wire logic        charge_start_i,
    input wire logic        in_charge_i,
    input wire logic        in_active_i,
    input wire logic        in_standby_i,
    input wire logic        limit_high_o,
    input wire logic [15:0] limit_mv_o,
    input wire logic [2:0]  vmin_code_o,
    input wire logic [2:0]  ich_code_o,
    input wire logic        ich_undefined_o,
    input wire logic [3:0]  ew_code_o,
    input wire logic        ew_enable_o,
    input wire logic        pulse_out_hiz_o,
    input wire logic        pulse_out_to_battery_o,
    input wire logic [5:0]  profile_index_o,
    input wire logic        fixed_mode_o,
    input wire logic [1:0]  margin_code_o,
    input wire logic [15:0] store_now_mv_o,
    input wire logic [15:0] target_mv_o
);
    // ****************************************************************
    // Shared timing
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // A write is only taken while the clock enable is high.
    sequence s_wr(a);
        ce_i && reg_wr_i && reg_addr_i == a;
    endsequence

    // ****************************************************************
    // Assertions
    // ****************************************************************
    chk_limit_value: assert property (limit_mv_o == (limit_high_o ? 16'h2af8 : 16'h26ac))
        else $error("limit voltage wrong");
    chk_input_write: assert property (s_wr(EMC_OFS_INPUT_CFG) |=> vmin_code_o == $past(reg_wdata_i[2:0])
        && ich_code_o == $past(reg_wdata_i[7:5]))
        else $error("input fields not loaded");
    chk_ich_undef: assert property (ich_undefined_o == (ich_code_o > EMC_ICH_EMERGENCY))
        else $error("undefined flag wrong");
    chk_warn_write: assert property (s_wr(EMC_OFS_WARNING_CFG) |=> ew_code_o == $past(reg_wdata_i[3:0])
        && ew_enable_o == $past(reg_wdata_i[4]))
        else $error("warning fields not loaded");
    chk_pin_mode: assert property ((pulse_out_hiz_o | pulse_out_to_battery_o) == (in_standby_i | in_active_i)
        && !(pulse_out_hiz_o && pulse_out_to_battery_o))
        else $error("pulse mode wrong");
    chk_profile_join: assert property (s_wr(EMC_OFS_PROFILE_HIGH) |=>
        profile_index_o[5:4] == $past(reg_wdata_i[1:0]))
        else $error("profile bits not loaded");
    chk_fixed_mode: assert property (fixed_mode_o == (profile_index_o == 6'h00))
        else $error("fixed mode wrong");
    chk_margin_hold: assert property (!(ce_i && reg_wr_i && reg_addr_i == EMC_OFS_MARGIN_CFG)
        |=> $stable(margin_code_o))
        else $error("margin moved unwritten");
    chk_store_frozen: assert property (!(in_charge_i || in_active_i) |=> $stable(store_now_mv_o))
        else $error("level moved in standby");
    chk_target_hold: assert property (!(ce_i && charge_start_i) |=> $stable(target_mv_o))
        else $error("target moved unprompted");
    chk_read_answer: assert property (ce_i && reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");
endmodule

bind emc_config_regs emc_config_regs_props #(.ADD_WIDTH(ADD_WIDTH)) i_props (.*);

// file: sim/emc_host_model.sv
// Host model that issues byte writes and reads on the register port.
// Assumes writes take effect at the strobe edge and reads answer one cycle later.
`timescale 1ns/1ps
module emc_host_model (
    input  wire logic       clk_i,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i
);
    initial begin
        addr_o  = 8'h00;
        wdata_o = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    // Released lines show the inverse so a stale value cannot pass by luck.
    task automatic put(input logic [7:0] a, d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask

    task automatic get(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        @(negedge clk_i);
        ok = rvalid_i;
        d  = rdata_i;
    endtask
endmodule

// file: sim/emc_config_regs_bench.sv
// Self-checking bench for the energy-manager register bank.
// Assumes the host model drives the register port and the bench drives all else.
`timescale 1ns/1ps
module emc_config_regs_bench
    import emc_pkg::*;
;
    // ****************************************************************
    // Signals and tables
    // ****************************************************************
    logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, rvalid, lim_h, ich_u, ew_en, hiz, bat, fixed;
    logic        charge_start_i = 1'b0, in_charge_i = 1'b0, in_active_i = 1'b0, in_standby_i = 1'b0;
    logic        energy_add_i = 1'b0, lim, hz, ee;
    logic [15:0] energy_amount_i = 16'h0000, lim_mv, vmin_mv, ich_ma, ew_mv, mg_mv, now_mv, tgt_mv;
    logic [7:0]  addr, wdata, rdata;
    logic        wr, rd;
    logic [4:0]  store_level_i = 5'h00, target_level_i = 5'h00;
    logic [2:0]  vmin_c, ich_c, vm, ic;
    logic [3:0]  ew_c, ew;
    logic [5:0]  prof, pr;
    logic [1:0]  mg_c, mg;
    logic [31:0] seed = 32'heeda7ecd, tot;
    int          errors = 0, num_checks = 0;
    localparam int LAD[32] = '{1400, 1510, 1800, 2190, 2400, 2600, 2790, 3010, 3200, 3410, 3610, 3990, 4390,
        4800, 5210, 5590, 5910, 6020, 6400, 6550, 6800, 7140, 7230, 7680, 8190, 8650, 9100, 9530, 9910, 10330,
        10690, 11070};
    localparam int ICH[5] = '{20, 40, 80, 160, 500};
    localparam int EWV[10] = '{2400, 2600, 2800, 3000, 3200, 3400, 3600, 4000, 4400, 4800};
    localparam int MGV[4] = '{3410, 4390, 5210, 5910};

    always #12.5 clk_i = ~clk_i;

    emc_host_model i_emc_host_model (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .rdata_i(rdata), .rvalid_i(rvalid));

    emc_config_regs i_emc_config_regs (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .charge_start_i(charge_start_i), .in_charge_i(in_charge_i), .in_active_i(in_active_i),
        .in_standby_i(in_standby_i), .energy_add_i(energy_add_i), .energy_amount_i(energy_amount_i),
        .store_level_async_i(store_level_i), .target_level_i(target_level_i), .limit_high_o(lim_h),
        .limit_mv_o(lim_mv), .vmin_code_o(vmin_c), .vmin_mv_o(vmin_mv), .ich_code_o(ich_c),
        .ich_ma_x10_o(ich_ma), .ich_undefined_o(ich_u), .ew_code_o(ew_c), .ew_mv_o(ew_mv),
        .ew_enable_o(ew_en), .pulse_out_hiz_o(hiz), .pulse_out_to_battery_o(bat), .profile_index_o(prof),
        .fixed_mode_o(fixed), .margin_code_o(mg_c), .margin_mv_o(mg_mv), .store_now_mv_o(now_mv),
        .target_mv_o(tgt_mv));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    function automatic int vmin_exp(input logic [2:0] c);
        return 2400 + 200 * int'(c);
    endfunction

    task automatic check(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic read_chk(input logic [7:0] a, exp);
        logic [7:0] d;
        logic       ok;
        i_emc_host_model.get(a, d, ok);
        check(ok, 1'b1);
        check(d, exp);
    endtask

    task automatic check_all();
        check(lim_mv, lim ? 32'h2af8 : 32'h26ac);
        check({vmin_c, vmin_mv}, {vm, 16'(vmin_exp(vm))});
        check({ich_c, ich_ma, ich_u}, {ic, 16'(ICH[ic]), 1'b0});
        check({ew_c, ew_mv}, {ew, 16'(EWV[ew])});
        check(ew_en, ee);
        check({hiz, bat}, (in_standby_i | in_active_i) ? (hz ? 2'h2 : 2'h1) : 2'h0);
        check({prof, fixed}, {pr, pr == 6'h00});
        check({mg_c, mg_mv}, {mg, 16'(MGV[mg])});
    endtask

    task automatic charge(input logic [4:0] t);
        @(posedge clk_i);
        charge_start_i <= 1'b1;
        target_level_i <= t;
        @(posedge clk_i);
        charge_start_i <= 1'b0;
        target_level_i <= ~t;
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        #(25ns * 20000);
        errors++;
        end_of_test();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        {lim, hz, ee, vm, ew, pr} = '0;
        ic = 3'h2;
        mg = 2'h3;
        @(negedge clk_i);
        check_all();
        read_chk(8'h0e, 8'h00);
        for (int i = 0; i < 40; i++) begin
            if (i == 20) begin
                ce_i <= 1'b0;
                i_emc_host_model.put(EMC_OFS_MARGIN_CFG, {6'h00, ~mg});
                ce_i <= 1'b1;
                @(negedge clk_i);
                check(mg_c, mg);
            end
            seed = xs(seed);
            {in_charge_i, in_active_i, in_standby_i} <= seed[30:28];
            if (i < 10) begin
                {vm, ic, ew, mg} = {3'(i % 5), 3'(i % 5), 4'(i), 2'(i)};
                pr = i[0] ? 6'h3f : 6'h00;
                {lim, hz, ee} = 3'(i);
            end else begin
                {vm, ic, ew} = {3'(seed % 5), 3'(seed[7:0] % 5), 4'(seed[15:8] % 10)};
                {mg, pr, lim, hz, ee} = seed[26:16];
            end
            i_emc_host_model.put(EMC_OFS_INPUT_CFG, {ic, hz, 1'b0, vm});
            i_emc_host_model.put(EMC_OFS_WARNING_CFG, {3'h0, ee, ew});
            i_emc_host_model.put(EMC_OFS_LIMIT_CFG, {3'h0, lim, 4'h0});
            i_emc_host_model.put(EMC_OFS_PROFILE_HIGH, {seed[31:26], pr[5:4]});
            i_emc_host_model.put(EMC_OFS_MODE_COMMAND, {pr[3:0], 4'h0});
            i_emc_host_model.put(EMC_OFS_MARGIN_CFG, {6'h00, mg});
            @(negedge clk_i);
            check_all();
        end
        read_chk(EMC_OFS_INPUT_CFG, 8'h00);
        {in_charge_i, in_active_i, in_standby_i} <= 3'h4;
        for (int c = 0; c < 32; c++) begin
            store_level_i <= 5'(31 - c);
            charge(5'(c));
            @(negedge clk_i);
            check(tgt_mv, LAD[c]);
            read_chk(EMC_OFS_TARGET, 8'(c));
            repeat (3) @(posedge clk_i);
            read_chk(EMC_OFS_STORE_NOW, 8'(31 - c));
            check(now_mv, LAD[31 - c]);
        end
        {in_charge_i, in_active_i, in_standby_i} <= 3'h1;
        store_level_i <= 5'h15;
        repeat (6) @(posedge clk_i);
        read_chk(EMC_OFS_STORE_NOW, 8'h00);
        tot = 32'h0;
        for (int k = 0; k < 6; k++) begin
            seed = xs(seed);
            @(posedge clk_i);
            energy_add_i    <= 1'b1;
            energy_amount_i <= seed[15:0];
            tot += seed[15:0];
        end
        @(posedge clk_i);
        energy_add_i <= 1'b0;
        for (int k = 0; k < 4; k++) read_chk(EMC_OFS_ENERGY_3 + 8'(k), tot[31 - 8 * k -: 8]);
        charge(5'h03);
        for (int k = 0; k < 4; k++) read_chk(EMC_OFS_ENERGY_3 + 8'(k), 8'h00);
        end_of_test();
    end
endmodule
